// ### rtl/uart_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the serial channel
// Assumes: 32-bit register words on byte addresses
// Notes:   Included by the channel core and its bench
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLK_SEL   8'h00
`define OFS_BAUD_HI   8'h04
`define OFS_BAUD_LO   8'h08
`define OFS_COMMAND   8'h0C
`define OFS_MODE      8'h10
`define OFS_STATUS    8'h14
`define OFS_DATA      8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSEL_EXT      0
`define CSEL_X1       1
`define CMD_TX_EN     0
`define CMD_TX_DIS    1
`define CMD_TX_RST    2
`define CMD_RX_EN     3
`define CMD_RX_DIS    4
`define CMD_RX_RST    5
`define CMD_BRK_ON    6
`define CMD_BRK_OFF   7
`define CMD_RTS_ON    8
`define CMD_RTS_OFF   9
`define MODE_LEN_LO   0
`define MODE_LEN_HI   1
`define MODE_PAR_EN   2
`define MODE_PAR_ODD  3
`define MODE_STOP2    4
`define MODE_CTS_FLOW 5
`define MODE_RX_RTS   6
`define MODE_TX_RTS   7
`define MODE_LOOP     8
`define MODE_RX_GPIO  9
`define MODE_TX_GPIO  10
`define MODE_RTS_GPIO 11
`define MODE_GPO_TX   12
`define MODE_GPO_RTS  13
`define ST_RX_RDY     0
`define ST_TX_RDY     1
`define ST_TX_EMP     2
`define ST_CTS_CHG    3
`define ST_CTS        4
`define ST_RX_PIN     5
`define ST_CTS_PIN    6
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_CSEL      2'h0
`define RST_BAUD      8'h00
`define RST_MODE      14'h0003
`define START_SAMPLES 4'h7
`define TICKS_X16     4'hF
`define TICKS_X1      4'h0
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ### rtl/uart_pkg.sv
// Purpose: Types of the serial channel core
// Assumes: Nothing beyond the header of constants
// Notes:   Bus structs carry the published AXI4-Lite names
package uart_pkg;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_LINGER} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;
endpackage : uart_pkg

// ### rtl/uart_tx_rx_core.sv
// Purpose: Serial channel with AXI4-Lite registers
// Assumes: aclk at 50 MHz, synchronous active-low reset
// Notes:   Receive holding is a single register
//
// Behaviour
// RULE1: Receive input sampled on rising ticks, LSB first.
// RULE2: Data pins act as general purpose pins or serial function.
// RULE3: Request-to-send active low; receiver or transmitter may drive it.
// RULE4: Clear-to-send active low; any change sets a sticky flag.
// RULE5: Clock select picks baud timer or external clock; timer at 16x.
// RULE6: Timer reload from upper and lower preload registers.
// RULE7: External clock drives both directions as x1 or x16.
// RULE8: Command enables transmitter; ready flag shows room for a character.
// RULE9: Frame: start, data LSB first, optional parity, stop bits.
// RULE10: Transmit output changes on falling ticks.
// RULE11: Nothing waiting after stop: output mark, empty flag set.
// RULE12: A written character clears the empty flag; sending resumes.
// RULE13: Disable finishes the shifted character, then stops.
// RULE14: Transmitter reset stops at once; enable resumes.
// RULE15: Clear-to-send gates character start; started characters complete.
// RULE16: Break drives output low and ignores clear-to-send.
// RULE17: Transmit-controlled request-to-send drops one bit after last character.
// RULE18: Start edge qualified by eight 16x samples, or next rising tick.
// RULE19: High qualification sample discards start; else sample bit centres.
// RULE20: After data, parity, one stop: load holding, set ready.
// RULE21: Unused upper bits of short characters are zero.
// RULE22: Receiver-ready rises at the stop bit middle.
// RULE23: Output holds mark when disabled, idle or in loopback.
`timescale 1ns/10ps
`default_nettype none
`include "uart_defs.svh"

module uart_tx_rx_core (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire uart_pkg::axi_req_s axi_req,
  output wire uart_pkg::axi_rsp_s axi_rsp,
  input  wire logic               serial_in0_pin,
  output wire logic               serial_out0_pin,
  output wire logic               send_request0_pin_n,
  input  wire logic               send_clear0_pin_n,
  input  wire logic               external_timer_clock_in
);
  import uart_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  csel;
    logic [7:0]  bg_hi;
    logic [7:0]  bg_lo;
    logic [13:0] mode;
    logic [15:0] timer;
    logic        clk16;
    logic [2:0]  rx_sync;
    logic [2:0]  cts_sync;
    logic [2:0]  ext_sync;
    logic        tx_en;
    logic        rx_en;
    logic        brk;
    logic        rts;
    tx_state_e   tx_st;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_shift;
    logic        tx_par;
    logic        tx_line;
    logic        stop2;
    logic [7:0]  tx_hold;
    logic        hold_full;
    logic        tx_empty;
    rx_state_e   rx_st;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_hold;
    logic        rx_ready;
    logic        rx_prev;
    logic        cts_chg;
    logic        txd;
    logic        rts_pin;
  } core_state_s;

  core_state_s st_r;
  core_state_s st_nxt;
  logic        rise;
  logic        fall;
  logic        x1;
  logic        rxd;
  logic        cts_ok;
  logic        can_start;
  logic        vstart;
  logic [3:0]  tpb_m1;
  logic [2:0]  nb_m1;
  logic [7:0]  mask;
  logic [32:0] hv;
  logic [32:0] rv;
  logic [31:0] wv;
  logic [31:0] cmd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
    end
    return m;
  endfunction : merge

  function automatic logic [32:0] reg_val(input logic [7:0] a);
    logic [32:0] v;
    v = 33'h0;
    v[32] = 1'b1;
    if (a == `OFS_CLK_SEL) v[1:0] = st_r.csel;
    else if (a == `OFS_BAUD_HI) v[7:0] = st_r.bg_hi;
    else if (a == `OFS_BAUD_LO) v[7:0] = st_r.bg_lo;
    else if (a == `OFS_COMMAND) v[31:0] = 32'h0;
    else if (a == `OFS_MODE) v[13:0] = st_r.mode;
    else if (a == `OFS_STATUS) begin
      v[`ST_RX_RDY]  = st_r.rx_ready;
      v[`ST_TX_RDY]  = st_r.tx_en & ~st_r.hold_full;
      v[`ST_TX_EMP]  = st_r.tx_empty;
      v[`ST_CTS_CHG] = st_r.cts_chg;
      v[`ST_CTS]     = ~st_r.cts_sync[1];
      v[`ST_RX_PIN]  = st_r.rx_sync[1];
      v[`ST_CTS_PIN] = st_r.cts_sync[1];
    end else if (a == `OFS_DATA) v[7:0] = st_r.rx_hold;
    else v = 33'h0;
    return v;
  endfunction : reg_val

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign axi_rsp.awready = ~st_r.aw_got & ~st_r.bvalid;
  assign axi_rsp.wready  = ~st_r.w_got & ~st_r.bvalid;
  assign axi_rsp.bvalid  = st_r.bvalid;
  assign axi_rsp.bresp   = st_r.bresp;
  assign axi_rsp.arready = ~st_r.rvalid;
  assign axi_rsp.rvalid  = st_r.rvalid;
  assign axi_rsp.rdata   = st_r.rdata;
  assign axi_rsp.rresp   = st_r.rresp;
  assign serial_out0_pin     = st_r.txd;
  assign send_request0_pin_n = st_r.rts_pin;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    rise   = 1'b0;
    fall   = 1'b0;
    vstart = 1'b0;
    hv     = reg_val(st_r.aw_addr);
    wv     = merge(hv[31:0], st_r.w_data, st_r.w_strb);
    cmd    = merge(32'h0, st_r.w_data, st_r.w_strb);
    rv     = reg_val(axi_req.araddr);
    st_nxt.rx_sync  = {st_r.rx_sync[1:0], serial_in0_pin};
    st_nxt.cts_sync = {st_r.cts_sync[1:0], send_clear0_pin_n};
    st_nxt.ext_sync = {st_r.ext_sync[1:0], external_timer_clock_in};
    x1     = st_r.csel[`CSEL_X1] & st_r.csel[`CSEL_EXT];
    tpb_m1 = x1 ? `TICKS_X1 : `TICKS_X16;
    nb_m1  = 3'd4 + {1'b0, st_r.mode[`MODE_LEN_HI:`MODE_LEN_LO]};
    mask   = 8'hFF >> (2'd3 - st_r.mode[`MODE_LEN_HI:`MODE_LEN_LO]);
    rxd    = st_r.mode[`MODE_LOOP] ? st_r.tx_line :
             (st_r.mode[`MODE_RX_GPIO] ? 1'b1 : st_r.rx_sync[1]); // RULE2
    cts_ok = ~st_r.mode[`MODE_CTS_FLOW] | ~st_r.cts_sync[1] | st_r.brk; // RULE15 RULE16
    can_start = st_r.tx_en & st_r.hold_full & cts_ok;

    if (st_r.csel[`CSEL_EXT]) begin
      rise = st_r.ext_sync[1] & ~st_r.ext_sync[2]; // RULE7
      fall = ~st_r.ext_sync[1] & st_r.ext_sync[2]; // RULE7
    end else if (st_r.timer == 16'h0000) begin
      st_nxt.timer = {st_r.bg_hi, st_r.bg_lo}; // RULE6
      st_nxt.clk16 = ~st_r.clk16; // RULE5
      rise = ~st_r.clk16;
      fall = st_r.clk16;
    end else begin
      st_nxt.timer = st_r.timer - 16'h0001;
    end
    // Bus write side
    if (axi_req.awvalid & axi_rsp.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid & axi_rsp.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end
    if (st_r.bvalid & axi_req.bready) st_nxt.bvalid = 1'b0;
    if (st_r.aw_got & st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = hv[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (st_r.aw_addr == `OFS_CLK_SEL) st_nxt.csel = wv[1:0]; // RULE5
      else if (st_r.aw_addr == `OFS_BAUD_HI) st_nxt.bg_hi = wv[7:0]; // RULE6
      else if (st_r.aw_addr == `OFS_BAUD_LO) st_nxt.bg_lo = wv[7:0]; // RULE6
      else if (st_r.aw_addr == `OFS_MODE) st_nxt.mode = wv[13:0];
      else if (st_r.aw_addr == `OFS_STATUS) begin
        if (st_r.w_strb[0] & st_r.w_data[`ST_CTS_CHG]) st_nxt.cts_chg = 1'b0;
      end else if (st_r.aw_addr == `OFS_DATA) begin
        if (st_r.w_strb[0] & st_r.tx_en & ~st_r.hold_full) begin
          st_nxt.tx_hold   = st_r.w_data[7:0];
          st_nxt.hold_full = 1'b1;
          st_nxt.tx_empty  = 1'b0; // RULE12
        end
      end
    end
    // Bus read side
    if (st_r.rvalid & axi_req.rready) st_nxt.rvalid = 1'b0;
    if (axi_req.arvalid & ~st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rv[31:0];
      st_nxt.rresp  = rv[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (axi_req.araddr == `OFS_DATA) begin
        st_nxt.rx_ready = 1'b0;
        if (st_r.mode[`MODE_RX_RTS]) st_nxt.rts = 1'b1; // RULE3
      end
    end
    // Transmitter, moves on falling ticks
    if (fall && st_r.tx_st != TX_IDLE) begin // RULE10
      if (st_r.tx_cnt != tpb_m1) begin
        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
      end else begin
        st_nxt.tx_cnt = 4'h0;
        case (st_r.tx_st)
          TX_START: begin
            st_nxt.tx_line = st_r.tx_shift[0]; // RULE9
            st_nxt.tx_st   = TX_DATA;
            st_nxt.tx_bit  = 3'h0;
          end
          TX_DATA: begin
            if (st_r.tx_bit == nb_m1) begin
              st_nxt.tx_line = st_r.mode[`MODE_PAR_EN] ? st_r.tx_par : 1'b1; // RULE9
              st_nxt.tx_st   = st_r.mode[`MODE_PAR_EN] ? TX_PARITY : TX_STOP;
              st_nxt.stop2   = st_r.mode[`MODE_STOP2];
            end else begin
              st_nxt.tx_bit   = st_r.tx_bit + 3'h1;
              st_nxt.tx_shift = st_r.tx_shift >> 1;
              st_nxt.tx_line  = st_r.tx_shift[1]; // RULE9
            end
          end
          TX_PARITY: begin
            st_nxt.tx_line = 1'b1;
            st_nxt.tx_st   = TX_STOP;
          end
          TX_STOP: begin
            if (st_r.stop2) begin
              st_nxt.stop2 = 1'b0; // RULE9
            end else begin
              if (~st_nxt.hold_full) st_nxt.tx_empty = 1'b1; // RULE11
              if (~st_r.tx_en & st_r.mode[`MODE_TX_RTS]) begin
                st_nxt.tx_st = TX_LINGER; // RULE17
              end else begin
                st_nxt.tx_st = TX_IDLE; // RULE11 RULE13
              end
            end
          end
          TX_LINGER: begin
            st_nxt.rts   = 1'b0; // RULE17 RULE3
            st_nxt.tx_st = TX_IDLE;
          end
          default: st_nxt.tx_st = TX_IDLE;
        endcase
      end
    end
    if (fall && st_nxt.tx_st == TX_IDLE && can_start) begin // RULE8 RULE15
      st_nxt.tx_shift  = st_r.tx_hold;
      st_nxt.hold_full = 1'b0;
      st_nxt.tx_par    = ^(st_r.tx_hold & mask) ^ st_r.mode[`MODE_PAR_ODD];
      st_nxt.tx_line   = 1'b0; // RULE9
      st_nxt.tx_st     = TX_START;
      st_nxt.tx_cnt    = 4'h0;
    end
    // Receiver, samples on rising ticks
    if (rise) begin // RULE1
      st_nxt.rx_prev = rxd;
      case (st_r.rx_st)
        RX_IDLE: begin
          if (st_r.rx_en & st_r.rx_prev & ~rxd) begin // RULE18
            st_nxt.rx_cnt   = 4'h0;
            st_nxt.rx_bit   = 3'h0;
            st_nxt.rx_shift = 8'h00; // RULE21
            st_nxt.rx_st    = x1 ? RX_DATA : RX_START;
            vstart          = x1;
          end
        end
        RX_START: begin
          if (rxd) st_nxt.rx_st = RX_IDLE; // RULE19
          else if (st_r.rx_cnt == `START_SAMPLES) begin
            st_nxt.rx_st  = RX_DATA; // RULE18 RULE19
            st_nxt.rx_cnt = 4'h0;
            vstart        = 1'b1;
          end else begin
            st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          end
        end
        default: begin
          if (st_r.rx_cnt != tpb_m1) begin
            st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          end else begin
            st_nxt.rx_cnt = 4'h0;
            if (st_r.rx_st == RX_DATA) begin
              st_nxt.rx_shift[st_r.rx_bit] = rxd; // RULE1 RULE19
              st_nxt.rx_bit = st_r.rx_bit + 3'h1;
              if (st_r.rx_bit == nb_m1) begin
                st_nxt.rx_st = st_r.mode[`MODE_PAR_EN] ? RX_PARITY : RX_STOP;
              end
            end else if (st_r.rx_st == RX_PARITY) begin
              st_nxt.rx_st = RX_STOP;
            end else begin
              st_nxt.rx_hold  = st_r.rx_shift; // RULE20 RULE21
              st_nxt.rx_ready = 1'b1; // RULE22
              st_nxt.rx_st    = RX_IDLE;
            end
          end
        end
      endcase
    end
    if (vstart & st_r.mode[`MODE_RX_RTS] & st_r.rx_ready) st_nxt.rts = 1'b0; // RULE3
    if (st_r.cts_sync[1] ^ st_r.cts_sync[2]) st_nxt.cts_chg = 1'b1; // RULE4
    // Commands
    if (st_r.aw_got & st_r.w_got & (st_r.aw_addr == `OFS_COMMAND)) begin
      if (cmd[`CMD_TX_EN]) st_nxt.tx_en = 1'b1; // RULE8
      if (cmd[`CMD_TX_DIS]) st_nxt.tx_en = 1'b0; // RULE13
      if (cmd[`CMD_TX_RST]) begin
        st_nxt.tx_en     = 1'b0; // RULE14
        st_nxt.tx_st     = TX_IDLE;
        st_nxt.tx_line   = 1'b1;
        st_nxt.tx_cnt    = 4'h0;
        st_nxt.hold_full = 1'b0;
        st_nxt.tx_empty  = 1'b1;
      end
      if (cmd[`CMD_RX_EN]) st_nxt.rx_en = 1'b1;
      if (cmd[`CMD_RX_DIS]) st_nxt.rx_en = 1'b0;
      if (cmd[`CMD_RX_RST]) begin
        st_nxt.rx_en    = 1'b0;
        st_nxt.rx_st    = RX_IDLE;
        st_nxt.rx_ready = 1'b0;
      end
      if (cmd[`CMD_BRK_ON]) st_nxt.brk = 1'b1; // RULE16
      if (cmd[`CMD_BRK_OFF]) st_nxt.brk = 1'b0;
      if (cmd[`CMD_RTS_ON]) st_nxt.rts = 1'b1; // RULE17
      if (cmd[`CMD_RTS_OFF]) st_nxt.rts = 1'b0;
    end
    // Pins
    st_nxt.txd = st_r.mode[`MODE_TX_GPIO] ? st_r.mode[`MODE_GPO_TX] : // RULE2
                 (st_r.mode[`MODE_LOOP] ? 1'b1 : // RULE23
                 (st_nxt.brk ? 1'b0 : st_nxt.tx_line)); // RULE16 RULE23
    st_nxt.rts_pin = st_r.mode[`MODE_RTS_GPIO] ? st_r.mode[`MODE_GPO_RTS] : ~st_nxt.rts; // RULE3
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.csel     <= `RST_CSEL;
      st_r.bg_hi    <= `RST_BAUD;
      st_r.bg_lo    <= `RST_BAUD;
      st_r.mode     <= `RST_MODE;
      st_r.rx_sync  <= 3'h7;
      st_r.cts_sync <= 3'h7;
      st_r.tx_line  <= 1'b1;
      st_r.tx_empty <= 1'b1;
      st_r.rx_prev  <= 1'b1;
      st_r.txd      <= 1'b1;
      st_r.rts_pin  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : uart_tx_rx_core
`default_nettype wire

// ### verification/serial_peer.sv
// Purpose: Remote serial peer
// Assumes: Bit length fixed here at 64 clocks; bench sets character format
// Notes:   Frames queued: data, parity bit 8, stop bit 9
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input  wire logic aclk,
  output var  logic to_dut,
  input  wire logic from_dut,
  output var  logic clear_n,
  input  wire logic request_n
);
  int   bit_cyc = 64;
  int   nbits   = 8;
  logic pe      = 1'b0;
  logic po      = 1'b0;
  int   got[$];
  // --------------
  // Both directions
  // --------------
  initial begin
    to_dut  = 1'b1;
    clear_n = 1'b0;
  end
  task automatic set_clear(input logic b);
    @(posedge aclk);
    clear_n <= b;
  endtask : set_clear
  task automatic hold(input logic b, input int n);
    @(posedge aclk);
    to_dut <= b;
    repeat (n - 1) @(posedge aclk);
  endtask : hold
  task automatic send(input logic [7:0] c);
    hold(1'b0, bit_cyc);
    for (int k = 0; k < nbits; k++) hold(c[k], bit_cyc);
    if (pe) hold(^(c & (8'hFF >> (8 - nbits))) ^ po, bit_cyc);
    hold(1'b1, bit_cyc);
  endtask : send
  always begin : rx_side
    int v;
    @(negedge from_dut);
    repeat (bit_cyc / 2) @(posedge aclk);
    if (!from_dut) begin
      v = 0;
      for (int k = 0; k < nbits; k++) begin
        repeat (bit_cyc) @(posedge aclk);
        v[k] = from_dut;
      end
      if (pe) repeat (bit_cyc) @(posedge aclk);
      v[8] = pe & from_dut;
      repeat (bit_cyc) @(posedge aclk);
      v[9] = from_dut;
      got.push_back(v);
    end
  end
endmodule : serial_peer
`default_nettype wire

// ### verification/uart_tx_rx_core_bench.sv
// Purpose: Bench of the channel core
// Assumes: Preload 1, 64 clocks a bit
// Notes:   Frames expected from the mode
`timescale 1ns/10ps
`default_nettype none
`include "uart_defs.svh"
module uart_tx_rx_core_bench;
  import uart_pkg::*;
  logic        aclk            = 1'b0;
  logic        aresetn         = 1'b0;
  logic        ext_clk         = 1'b0;
  logic        ext_on          = 1'b0;
  logic [1:0]  ec              = 2'h0;
  axi_req_s    req             = '0;
  axi_rsp_s    rsp;
  wire logic   txd;
  wire logic   rxd;
  wire logic   rts_n;
  wire logic   cts_n;
  int          err_total       = 0;
  int          samples_checked = 0;
  logic [7:0]  lf              = 8'h3E;
  logic [2:0]  m;
  logic [31:0] v;
  logic [31:0] rst_tab [8]     = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h34, 32'h0, 32'h0};
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    ec      <= ec + 2'h1;
    ext_clk <= ext_on & ec[1];
  end
  uart_tx_rx_core dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .serial_in0_pin(rxd), .serial_out0_pin(txd), .send_request0_pin_n(rts_n),
    .send_clear0_pin_n(cts_n), .external_timer_clock_in(ext_clk));
  serial_peer peer (.aclk(aclk), .to_dut(rxd), .from_dut(txd), .clear_n(cts_n),
    .request_n(rts_n));
  // --------------
  // Tasks
  // --------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] frame(input logic [7:0] c, input int n, input logic pe,
                                        input logic po);
    logic [7:0] d;
    d = c & (8'hFF >> (8 - n));
    return {22'h0, 1'b1, pe & (^d ^ po), d};
  endfunction : frame
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic lapse();
    err_total++;
    conclude();
  endtask : lapse
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid && req.bready) break;
      if (rsp.bvalid) req.bready <= 1'b1;
    end
    req.bready <= 1'b0;
    if (n == 50) lapse();
    chk("bresp", rsp.bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready) break;
      if (rsp.rvalid) req.rready <= 1'b1;
    end
    d = rsp.rdata;
    req.rready <= 1'b0;
    if (n == 50) lapse();
  endtask : rd
  task automatic take(input logic [31:0] exp);
    int n;
    for (n = 0; n < 3000 && peer.got.size() == 0; n++) @(posedge aclk);
    if (n == 3000) lapse();
    chk("tx frame", peer.got.pop_front(), exp);
  endtask : take
  task automatic send_tx();
    lf = lfsr(lf);
    wr(`OFS_DATA, {24'h0, lf});
    rd(`OFS_STATUS, v);
    chk("tx empty", v[`ST_TX_EMP], 1'b0);
    take(frame(lf, peer.nbits, peer.pe, peer.po));
  endtask : send_tx
  task automatic flush();
    tick(800);
    peer.got.delete();
  endtask : flush
  // --------------
  // Main sequence
  // --------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), v);
      chk("reset", v & ((i == 5) ? 32'hF7 : 32'hFFFFFFFF), rst_tab[i]);
    end
    wr(8'h1C, 32'h0, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'h8);
    wr(`OFS_BAUD_LO, 32'h1);
    wr(`OFS_COMMAND, 32'h9);
    rd(`OFS_STATUS, v);
    chk("tx ready", v[`ST_TX_RDY], 1'b1);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      peer.nbits = 5 + m[1:0];
      peer.pe = m[2];
      peer.po = m[0];
      wr(`OFS_MODE, {27'h0, m[1], m[0], m[2], m[1:0]});
      send_tx();
      lf = lfsr(lf);
      peer.send(lf);
      rd(`OFS_STATUS, v);
      chk("rx ready", v[`ST_RX_RDY], 1'b1);
      rd(`OFS_DATA, v);
      chk("rx char", v, {24'h0, lf & (8'hFF >> (3 - m[1:0]))});
      rd(`OFS_STATUS, v);
      chk("rx clr", v[`ST_RX_RDY], 1'b0);
    end
    rd(`OFS_STATUS, v);
    chk("idle", {v[`ST_TX_EMP], txd}, 2'h3);
    wr(`OFS_MODE, 32'h3);
    peer.pe = 1'b0;
    peer.hold(1'b0, 8);
    peer.hold(1'b1, 700);
    rd(`OFS_STATUS, v);
    chk("false start", v[`ST_RX_RDY], 1'b0);
    $display("framing done");
    wr(`OFS_MODE, 32'h23);
    peer.set_clear(1'b1);
    wr(`OFS_DATA, 32'hC3);
    tick(300);
    chk("cts hold", peer.got.size(), 32'h0);
    rd(`OFS_STATUS, v);
    chk("cts chg", v[`ST_CTS_CHG], 1'b1);
    peer.set_clear(1'b0);
    tick(100);
    peer.set_clear(1'b1);
    take(frame(8'hC3, 8, 1'b0, 1'b0));
    wr(`OFS_COMMAND, 32'h40);
    tick(4);
    chk("break", txd, 1'b0);
    wr(`OFS_COMMAND, 32'h80);
    tick(4);
    chk("break end", txd, 1'b1);
    peer.set_clear(1'b0);
    flush();
    wr(`OFS_DATA, 32'h0);
    tick(150);
    wr(`OFS_COMMAND, 32'h4);
    tick(4);
    chk("tx reset", txd, 1'b1);
    rd(`OFS_STATUS, v);
    chk("rst rdy", v[`ST_TX_RDY], 1'b0);
    flush();
    $display("flow done");
    wr(`OFS_MODE, 32'h83);
    wr(`OFS_COMMAND, 32'h101);
    tick(3);
    chk("rts on", rts_n, 1'b0);
    wr(`OFS_DATA, 32'h5A);
    wr(`OFS_DATA, 32'hA5);
    wr(`OFS_COMMAND, 32'h2);
    take(frame(8'h5A, 8, 1'b0, 1'b0));
    tick(64);
    chk("rts kept", rts_n, 1'b0);
    tick(64);
    chk("rts off", rts_n, 1'b1);
    chk("held", peer.got.size(), 32'h0);
    wr(`OFS_COMMAND, 32'h1);
    take(frame(8'hA5, 8, 1'b0, 1'b0));
    for (int b = 0; b < 2; b++) begin
      wr(`OFS_MODE, 32'hC03 | (b << 12) | (b << 13));
      tick(3);
      chk("gpo pins", {txd, rts_n}, {2{1'(b)}});
    end
    wr(`OFS_MODE, 32'h3);
    flush();
    ext_on <= 1'b1;
    wr(`OFS_CLK_SEL, 32'h1);
    send_tx();
    lf = lfsr(lf);
    peer.send(lf);
    rd(`OFS_DATA, v);
    chk("ext rx", v, {24'h0, lf});
    $display("modes done");
    conclude();
  end
endmodule : uart_tx_rx_core_bench
`default_nettype wire

// ### verification/uart_tx_rx_core_monitor.sv
// Purpose: Port checks
// Assumes: Bound to the core
// Notes:   Ports only
`timescale 1ns/10ps
`default_nettype none
module uart_tx_rx_core_monitor (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire uart_pkg::axi_req_s axi_req,
  input wire uart_pkg::axi_rsp_s axi_rsp,
  input wire logic               serial_in0_pin,
  input wire logic               serial_out0_pin,
  input wire logic               send_request0_pin_n,
  input wire logic               send_clear0_pin_n,
  input wire logic               external_timer_clock_in
);
  import uart_pkg::*;
  // --------------
  // Properties
  // --------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_mark; disable iff (1'b0) !aresetn |=> serial_out0_pin; endproperty
  a_rst_mark: assert property (p_rst_mark) else $error("no mark in reset");
  property p_rst_rts; disable iff (1'b0) !aresetn |=> send_request0_pin_n; endproperty
  a_rst_rts: assert property (p_rst_rts) else $error("rts in reset");
  property p_start; $fell(serial_out0_pin) |=> !serial_out0_pin; endproperty
  a_start: assert property (p_start) else $error("short low");
  property p_b_due; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid; endproperty
  a_b_due: assert property (p_b_due) else $error("b late");
  property p_b_hold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_r_due; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_r_due: assert property (p_r_due) else $error("r late");
  property p_r_hold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r changed");
  property p_r_block; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
  a_r_block: assert property (p_r_block) else $error("ar while busy");
endmodule : uart_tx_rx_core_monitor
bind uart_tx_rx_core uart_tx_rx_core_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .serial_in0_pin(serial_in0_pin), .serial_out0_pin(serial_out0_pin),
  .send_request0_pin_n(send_request0_pin_n), .send_clear0_pin_n(send_clear0_pin_n),
  .external_timer_clock_in(external_timer_clock_in));
`default_nettype wire
